// ===== hw/ots_map.vh
// Constants for the optical time slot sequencer: slot count, field widths,
// timer clock choices, bias and ambient mode encodings, phase times.
// Assumes a 100 MHz core clock; phase times are counted in whole microseconds.
`ifndef OTS_MAP_VH
`define OTS_MAP_VH

// ====================================================================
// Clock and time base
`define OTS_CLK_PERIOD_NS 10
`define OTS_NS_PER_US 1000
`define OTS_US_CYCLES (`OTS_NS_PER_US / `OTS_CLK_PERIOD_NS)
`define OTS_US_CNT_W 7
`define OTS_PRE_DEFAULT_US 8'h08
`define OTS_COARSE_US 8'h30

// ====================================================================
// Slots and per-slot field widths
`define OTS_NUM_SLOTS 12
`define OTS_IDX_W 4
`define OTS_IDX_NONE 4'hF
`define OTS_IDX_FIRST 4'h0
`define OTS_IDX_LAST 4'hB
`define OTS_TIME_W 8
`define OTS_LED_W 7
`define OTS_ROUTE_W 3
`define OTS_BIAS_W 3
`define OTS_AMB_W 9
`define OTS_AMODE_W 2
`define OTS_CHAN_W 3

// ====================================================================
// Timer clock source select
`define OTS_SRC_INT_A 3'h0
`define OTS_SRC_EXT_960K 3'h1
`define OTS_SRC_INT_B 3'h2
`define OTS_SRC_EXT_32M 3'h3
`define OTS_SRC_PIN 3'h4
`define OTS_DIV32_MAX 5'h1F

// ====================================================================
// Input bias selections (idle and precondition)
`define OTS_BIAS_FLOAT 3'h0
`define OTS_BIAS_SENSOR 3'h1
`define OTS_BIAS_REF 3'h2
`define OTS_BIAS_AMP_IN 3'h3
`define OTS_BIAS_SHORT 3'h4
`define OTS_BIAS_NONE 3'h7

// ====================================================================
// Readout channel numbers, 0 means not connected
`define OTS_CH_NONE 3'h0
`define OTS_CH_1 3'h1
`define OTS_CH_2 3'h2
`define OTS_CH_3 3'h3
`define OTS_CH_4 3'h4

// ====================================================================
// Ambient cancellation modes
`define OTS_AMB_COARSE 2'h0
`define OTS_AMB_FINE 2'h1
`define OTS_AMB_HOST 2'h2

// ====================================================================
// Slot phases seen by the input routers
`define OTS_PH_IDLE 2'h0
`define OTS_PH_PRECON 2'h1
`define OTS_PH_SAMPLE 2'h2

`endif

// ===== hw/ots_timer_sel.v
// Timer tick selector: picks one of the slow clock tick sources.
// Assumes every tick input is a one-cycle pulse synchronous to i_core_clk.
`include "ots_map.vh"

module ots_timer_sel (
    // Clock and reset
    input wire i_core_clk,
    input wire i_rst,
    input wire i_ce,
    // Selection
    input wire [2:0] i_clock_source_select,
    input wire i_timer_pin_clock_choice,
    // Tick sources
    input wire i_int_960k_tick,
    input wire i_ext_960k_tick,
    input wire i_ext_32m_tick,
    input wire i_ext_32k_tick,
    // Selected timer tick
    output reg o_tick
);

    reg [4:0] div_cnt;
    wire div_tick;

    // ====================================================================
    // Divide external 32 MHz by 32 to give 1 MHz
    assign div_tick = i_ext_32m_tick && (div_cnt == `OTS_DIV32_MAX);

    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            div_cnt <= 5'h0;
        end else if (i_ce && i_ext_32m_tick) begin
            div_cnt <= div_cnt + 5'h1;
        end
    end

    // ====================================================================
    // Source choice
    always @* begin
        case (i_clock_source_select)
            `OTS_SRC_INT_A: o_tick = i_int_960k_tick; // see RULE_04
            `OTS_SRC_EXT_960K: o_tick = i_ext_960k_tick; // see RULE_04
            `OTS_SRC_INT_B: o_tick = i_int_960k_tick; // see RULE_04
            `OTS_SRC_EXT_32M: o_tick = div_tick; // see RULE_04
            `OTS_SRC_PIN: o_tick = i_timer_pin_clock_choice ? i_ext_960k_tick : i_ext_32k_tick; // see RULE_04
            default: o_tick = i_int_960k_tick;
        endcase
    end

endmodule

// ===== hw/ots_pair_route.v
// Input pair router: maps one input pair to readout channels and picks
// the bias each input sees in idle, precondition and sampling.
// Assumes the sequencer presents the current slot's fields and phase.
`include "ots_map.vh"

module ots_pair_route (
    // Global pair settings
    input wire i_differential,
    input wire [`OTS_BIAS_W-1:0] i_idle_state,
    // Current slot settings
    input wire [`OTS_ROUTE_W-1:0] i_route,
    input wire [`OTS_BIAS_W-1:0] i_precon,
    input wire [1:0] i_phase,
    // Per input results
    output reg [`OTS_CHAN_W-1:0] o_chan_a,
    output reg [`OTS_CHAN_W-1:0] o_chan_b,
    output reg [`OTS_BIAS_W-1:0] o_bias_a,
    output reg [`OTS_BIAS_W-1:0] o_bias_b,
    output reg o_swap
);

    wire enabled;
    wire active;

    assign enabled = i_route[2];
    assign active = enabled && (i_phase != `OTS_PH_IDLE); // see RULE_10

    always @* begin
        o_chan_a = `OTS_CH_NONE;
        o_chan_b = `OTS_CH_NONE;
        o_swap = 1'b0;
        // Channels are only connected in the sampling phase
        if (active && i_phase == `OTS_PH_SAMPLE) begin // see RULE_07
            if (i_differential) begin // see RULE_06
                // Pair only ever lands on channel 1 or 2
                o_chan_a = i_route[0] ? `OTS_CH_2 : `OTS_CH_1; // see RULE_08
                o_chan_b = o_chan_a;
                o_swap = i_route[1];
            end else begin
                case (i_route[1:0])
                    2'h0: begin
                        o_chan_a = `OTS_CH_1;
                        o_chan_b = `OTS_CH_2;
                    end
                    2'h1: begin
                        o_chan_a = `OTS_CH_2;
                        o_chan_b = `OTS_CH_1;
                    end
                    2'h2: begin
                        o_chan_a = `OTS_CH_3;
                        o_chan_b = `OTS_CH_4;
                    end
                    default: begin
                        o_chan_a = `OTS_CH_4;
                        o_chan_b = `OTS_CH_3;
                    end
                endcase
            end
        end
        if (!active) begin
            o_bias_a = i_idle_state; // see RULE_09
            o_bias_b = i_idle_state;
        end else if (i_phase == `OTS_PH_PRECON) begin
            o_bias_a = i_precon; // see RULE_11
            o_bias_b = i_precon;
        end else begin
            o_bias_a = `OTS_BIAS_NONE; // see RULE_13
            o_bias_b = `OTS_BIAS_NONE;
        end
    end

endmodule

// ===== hw/ots_sequencer.v
// Optical time slot sequencer: runs up to twelve slots per sampling period,
// drives LED enables, input routing, bias and ambient cancellation control.
// Assumes configuration ports are held stable by host logic and all tick and
// strobe inputs are one-cycle pulses synchronous to i_core_clk.
//
// Function
// RULE_01: Twelve configurable slots, A through L.
// RULE_02: Each enabled slot runs once per period.
// RULE_03: Period counter counts timer clock ticks.
// RULE_04: Source select picks the timer clock.
// RULE_05: Two LED drivers per slot, 7-bit codes.
// RULE_06: Global bit makes each pair differential.
// RULE_07: Per-slot routing enables pair, picks channels.
// RULE_08: Differential only to channels one and two.
// RULE_09: Disabled or idle inputs take idle state.
// RULE_10: Inputs active only in precondition and pulse; the code also keeps them active in the coarse ambient window.
// RULE_11: Per-slot precondition bias selection.
// RULE_12: Slot opens with precondition, default 8 us.
// RULE_13: Bias disconnected while input is sampled.
// RULE_14: Per-slot ambient mode: coarse, fine, host.
// RULE_15: Coarse modes measure ambient for 48 us.
// RULE_16: Acquisition starts only after coarse baseline.
// RULE_17: Coarse-only holds code for the slot.
// RULE_18: Fine mode updates code after dark samples.
// RULE_19: Host mode uses host code, no tuning.
// RULE_20: Ambient code subtracted at chain front.
// RULE_21: Host ambient codes are 9-bit fields.
// RULE_22: Fine loop only in digital integration.
// RULE_23: Slots run A to L, then sleep.
`include "ots_map.vh"

module ots_sequencer #(
    parameter PERIOD_W = 16,
    parameter NSLOT = `OTS_NUM_SLOTS // see RULE_01
) (
    // Clock, reset, enable
    input wire i_core_clk,
    input wire i_rst,
    input wire i_ce,
    // Timer clock sources and choice
    input wire [2:0] i_clock_source_select,
    input wire i_timer_pin_clock_choice,
    input wire i_int_960k_tick,
    input wire i_ext_960k_tick,
    input wire i_ext_32m_tick,
    input wire i_ext_32k_tick,
    // Global settings
    input wire [PERIOD_W-1:0] i_slot_period,
    input wire i_inputs_one_two_differential,
    input wire i_inputs_three_four_differential,
    input wire [`OTS_BIAS_W-1:0] i_idle_state_first_pair,
    input wire [`OTS_BIAS_W-1:0] i_idle_state_second_pair,
    // Per-slot settings, slot A in the low bits
    input wire [NSLOT-1:0] i_slot_enable,
    input wire [NSLOT*2-1:0] i_slot_led_enable,
    input wire [NSLOT*`OTS_LED_W-1:0] i_slot_led_code_one,
    input wire [NSLOT*`OTS_LED_W-1:0] i_slot_led_code_two,
    input wire [NSLOT*`OTS_ROUTE_W-1:0] i_slot_route_first_pair,
    input wire [NSLOT*`OTS_ROUTE_W-1:0] i_slot_route_second_pair,
    input wire [NSLOT*`OTS_BIAS_W-1:0] i_slot_precondition_select,
    input wire [NSLOT*`OTS_TIME_W-1:0] i_slot_precon_width,
    input wire [NSLOT*`OTS_TIME_W-1:0] i_slot_pulse_width,
    input wire [NSLOT*`OTS_AMODE_W-1:0] i_slot_ambient_mode,
    input wire [NSLOT-1:0] i_slot_digital_integration,
    input wire [NSLOT*`OTS_AMB_W-1:0] i_host_ambient_code_channel_one,
    input wire [NSLOT*`OTS_AMB_W-1:0] i_host_ambient_code_channel_two,
    // Receiver feedback
    input wire [`OTS_AMB_W-1:0] i_amb_measured_ch1,
    input wire [`OTS_AMB_W-1:0] i_amb_measured_ch2,
    input wire i_dark_sample_done,
    // Sequencer status
    output reg [`OTS_IDX_W-1:0] o_slot_index,
    output wire o_slot_busy,
    output wire o_period_start,
    output wire o_acquire,
    output wire o_amb_measure,
    // LED drive
    output reg [1:0] o_led_enable,
    output reg [`OTS_LED_W-1:0] o_led_code_one,
    output reg [`OTS_LED_W-1:0] o_led_code_two,
    // Input switch matrix
    output wire [`OTS_CHAN_W-1:0] o_in1_chan,
    output wire [`OTS_CHAN_W-1:0] o_in2_chan,
    output wire [`OTS_CHAN_W-1:0] o_in3_chan,
    output wire [`OTS_CHAN_W-1:0] o_in4_chan,
    output wire [`OTS_BIAS_W-1:0] o_in1_bias,
    output wire [`OTS_BIAS_W-1:0] o_in2_bias,
    output wire [`OTS_BIAS_W-1:0] o_in3_bias,
    output wire [`OTS_BIAS_W-1:0] o_in4_bias,
    output wire o_first_pair_swap,
    output wire o_second_pair_swap,
    // Ambient cancellation DACs
    output reg [`OTS_AMB_W-1:0] o_amb_code_ch1,
    output reg [`OTS_AMB_W-1:0] o_amb_code_ch2,
    output wire o_amb_subtract
);

    // ====================================================================
    // State encoding
    localparam ST_SLEEP = 3'h0;
    localparam ST_PICK = 3'h1;
    localparam ST_PRECON = 3'h2;
    localparam ST_COARSE = 3'h3;
    localparam ST_PULSE = 3'h4;

    reg [2:0] state;
    reg [2:0] next_state;
    reg [PERIOD_W-1:0] period_cnt;
    reg [`OTS_US_CNT_W-1:0] us_cnt;
    reg [`OTS_TIME_W-1:0] phase_cnt;
    reg [`OTS_TIME_W-1:0] next_phase_cnt;
    reg [`OTS_IDX_W-1:0] next_index;
    reg [`OTS_IDX_W-1:0] search_from;
    reg [`OTS_IDX_W-1:0] found;
    reg [1:0] phase;
    reg start_pending;
    wire timer_tick;
    wire us_tick;
    wire period_hit;
    wire phase_end;

    // Current slot fields
    wire [`OTS_TIME_W-1:0] cur_pre;
    wire [`OTS_TIME_W-1:0] cur_pulse;
    wire [`OTS_TIME_W-1:0] pre_len;
    wire [`OTS_TIME_W-1:0] pulse_len;
    wire [`OTS_AMODE_W-1:0] cur_mode;
    wire cur_coarse;
    wire cur_fine;

    // ====================================================================
    // Timer tick and period counter
    ots_timer_sel u_timer_sel (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_clock_source_select(i_clock_source_select),
        .i_timer_pin_clock_choice(i_timer_pin_clock_choice),
        .i_int_960k_tick(i_int_960k_tick),
        .i_ext_960k_tick(i_ext_960k_tick),
        .i_ext_32m_tick(i_ext_32m_tick),
        .i_ext_32k_tick(i_ext_32k_tick),
        .o_tick(timer_tick)
    );

    // A period of zero stops sampling
    assign period_hit = timer_tick && (i_slot_period != {PERIOD_W{1'b0}}) &&
        (period_cnt >= i_slot_period - {{(PERIOD_W-1){1'b0}}, 1'b1}); // see RULE_03
    assign o_period_start = i_ce && period_hit;

    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            period_cnt <= {PERIOD_W{1'b0}};
        end else if (i_ce && timer_tick) begin
            if (period_hit) begin
                period_cnt <= {PERIOD_W{1'b0}};
            end else begin
                period_cnt <= period_cnt + {{(PERIOD_W-1){1'b0}}, 1'b1}; // see RULE_03
            end
        end
    end

    // ====================================================================
    // Microsecond tick from the core clock
    assign us_tick = (us_cnt == `OTS_US_CYCLES - 1);

    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            us_cnt <= {`OTS_US_CNT_W{1'b0}};
        end else if (i_ce) begin
            if (us_tick || state == ST_PICK) begin
                us_cnt <= {`OTS_US_CNT_W{1'b0}};
            end else begin
                us_cnt <= us_cnt + {{(`OTS_US_CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // ====================================================================
    // Slot field selection
    assign cur_pre = i_slot_precon_width[o_slot_index*`OTS_TIME_W +: `OTS_TIME_W];
    assign cur_pulse = i_slot_pulse_width[o_slot_index*`OTS_TIME_W +: `OTS_TIME_W];
    // Zero width falls back to the default precondition time
    assign pre_len = (cur_pre == {`OTS_TIME_W{1'b0}}) ? `OTS_PRE_DEFAULT_US : cur_pre; // see RULE_12
    assign pulse_len = (cur_pulse == {`OTS_TIME_W{1'b0}}) ? 8'h01 : cur_pulse;
    assign cur_mode = i_slot_ambient_mode[o_slot_index*`OTS_AMODE_W +: `OTS_AMODE_W];
    assign cur_coarse = (cur_mode != `OTS_AMB_HOST); // see RULE_14
    assign cur_fine = (cur_mode == `OTS_AMB_FINE) && i_slot_digital_integration[o_slot_index]; // see RULE_22

    // ====================================================================
    // Next enabled slot at or after search_from
    always @* begin : find_slot
        integer k;
        found = `OTS_IDX_NONE;
        for (k = NSLOT - 1; k >= 0; k = k - 1) begin
            if (i_slot_enable[k] && k >= search_from) begin
                found = k[`OTS_IDX_W-1:0]; // see RULE_23
            end
        end
    end

    always @* begin
        if (state == ST_SLEEP || o_slot_index == `OTS_IDX_LAST) begin
            search_from = (state == ST_SLEEP) ? `OTS_IDX_FIRST : `OTS_IDX_NONE;
        end else begin
            search_from = o_slot_index + 4'h1;
        end
    end

    // ====================================================================
    // Slot state machine
    assign phase_end = us_tick && (phase_cnt == 8'h01);

    always @* begin
        next_state = state;
        next_phase_cnt = phase_cnt;
        next_index = o_slot_index;
        case (state)
            ST_SLEEP: begin
                // Sleep until the period expires
                if (period_hit || start_pending) begin // see RULE_02
                    next_state = ST_PICK;
                    next_index = found;
                end
            end
            ST_PICK: begin
                if (o_slot_index == `OTS_IDX_NONE) begin
                    next_state = ST_SLEEP;
                    next_index = `OTS_IDX_FIRST;
                end else begin
                    next_state = ST_PRECON; // see RULE_12
                    next_phase_cnt = pre_len;
                end
            end
            ST_PRECON: begin
                if (phase_end) begin
                    if (cur_coarse) begin
                        next_state = ST_COARSE; // see RULE_15
                        next_phase_cnt = `OTS_COARSE_US;
                    end else begin
                        next_state = ST_PULSE; // see RULE_19
                        next_phase_cnt = pulse_len;
                    end
                end else if (us_tick) begin
                    next_phase_cnt = phase_cnt - 8'h01;
                end
            end
            ST_COARSE: begin
                if (phase_end) begin
                    next_state = ST_PULSE; // see RULE_16
                    next_phase_cnt = pulse_len;
                end else if (us_tick) begin
                    next_phase_cnt = phase_cnt - 8'h01;
                end
            end
            ST_PULSE: begin
                if (phase_end) begin
                    next_state = ST_PICK; // see RULE_23
                    next_index = found;
                end else if (us_tick) begin
                    next_phase_cnt = phase_cnt - 8'h01;
                end
            end
            default: begin
                next_state = ST_SLEEP;
                next_index = `OTS_IDX_FIRST;
            end
        endcase
    end

    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= ST_SLEEP;
            phase_cnt <= {`OTS_TIME_W{1'b0}};
            o_slot_index <= `OTS_IDX_FIRST;
            start_pending <= 1'b0;
        end else if (i_ce) begin
            state <= next_state;
            phase_cnt <= next_phase_cnt;
            o_slot_index <= next_index;
            // A period boundary during a running sequence starts the next one late
            if (period_hit && state != ST_SLEEP) begin
                start_pending <= 1'b1;
            end else if (state == ST_SLEEP) begin
                start_pending <= 1'b0;
            end
        end
    end

    assign o_slot_busy = (state != ST_SLEEP);
    assign o_amb_measure = (state == ST_COARSE); // see RULE_15
    assign o_acquire = (state == ST_PULSE); // see RULE_16
    assign o_amb_subtract = (state == ST_PULSE); // see RULE_20

    // ====================================================================
    // Phase seen by the input routers
    always @* begin
        case (state)
            ST_PRECON: phase = `OTS_PH_PRECON;
            ST_COARSE: phase = `OTS_PH_SAMPLE;
            ST_PULSE: phase = `OTS_PH_SAMPLE;
            default: phase = `OTS_PH_IDLE; // see RULE_10
        endcase
    end

    ots_pair_route u_route_first (
        .i_differential(i_inputs_one_two_differential),
        .i_idle_state(i_idle_state_first_pair),
        .i_route(i_slot_route_first_pair[o_slot_index*`OTS_ROUTE_W +: `OTS_ROUTE_W]),
        .i_precon(i_slot_precondition_select[o_slot_index*`OTS_BIAS_W +: `OTS_BIAS_W]),
        .i_phase(phase),
        .o_chan_a(o_in1_chan),
        .o_chan_b(o_in2_chan),
        .o_bias_a(o_in1_bias),
        .o_bias_b(o_in2_bias),
        .o_swap(o_first_pair_swap)
    );

    ots_pair_route u_route_second (
        .i_differential(i_inputs_three_four_differential),
        .i_idle_state(i_idle_state_second_pair),
        .i_route(i_slot_route_second_pair[o_slot_index*`OTS_ROUTE_W +: `OTS_ROUTE_W]),
        .i_precon(i_slot_precondition_select[o_slot_index*`OTS_BIAS_W +: `OTS_BIAS_W]),
        .i_phase(phase),
        .o_chan_a(o_in3_chan),
        .o_chan_b(o_in4_chan),
        .o_bias_a(o_in3_bias),
        .o_bias_b(o_in4_bias),
        .o_swap(o_second_pair_swap)
    );

    // ====================================================================
    // LED drive, only inside the pulse region
    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_led_enable <= 2'h0;
            o_led_code_one <= {`OTS_LED_W{1'b0}};
            o_led_code_two <= {`OTS_LED_W{1'b0}};
        end else if (i_ce) begin
            if (next_state == ST_PULSE) begin
                o_led_enable <= i_slot_led_enable[next_index*2 +: 2]; // see RULE_05
                o_led_code_one <= i_slot_led_code_one[next_index*`OTS_LED_W +: `OTS_LED_W];
                o_led_code_two <= i_slot_led_code_two[next_index*`OTS_LED_W +: `OTS_LED_W];
            end else begin
                o_led_enable <= 2'h0;
            end
        end
    end

    // ====================================================================
    // Ambient DAC codes
    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_amb_code_ch1 <= {`OTS_AMB_W{1'b0}};
            o_amb_code_ch2 <= {`OTS_AMB_W{1'b0}};
        end else if (i_ce) begin
            if (state == ST_PICK && !cur_coarse && o_slot_index != `OTS_IDX_NONE) begin
                // Host supplies the correction directly
                o_amb_code_ch1 <= i_host_ambient_code_channel_one[o_slot_index*`OTS_AMB_W +: `OTS_AMB_W]; // see RULE_21
                o_amb_code_ch2 <= i_host_ambient_code_channel_two[o_slot_index*`OTS_AMB_W +: `OTS_AMB_W]; // see RULE_19
            end else if (state == ST_COARSE && phase_end) begin
                // Coarse baseline taken at the end of the measure window
                o_amb_code_ch1 <= i_amb_measured_ch1; // see RULE_15
                o_amb_code_ch2 <= i_amb_measured_ch2;
            end else if (state == ST_PULSE && cur_fine && i_dark_sample_done) begin
                o_amb_code_ch1 <= i_amb_measured_ch1; // see RULE_18
                o_amb_code_ch2 <= i_amb_measured_ch2;
            end
            // Coarse-only slots keep the baseline unchanged; see RULE_17
        end
    end

endmodule

// ===== verification/ots_seq_properties.sv
// Port checker for the slot sequencer.
// Assumes i_ce is held high by the bench.
module ots_seq_chk (
    input wire logic i_core_clk, i_rst, i_inputs_three_four_differential, i_dark_sample_done,
    input wire logic o_slot_busy, o_period_start, o_acquire, o_amb_measure,
    input wire logic [2:0] i_idle_state_first_pair, o_in1_chan, o_in3_chan, o_in1_bias,
    input wire logic [1:0] o_led_enable,
    input wire logic [8:0] o_amb_code_ch1
);
    logic [12:0] win;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    // Length of the current ambient window
    always_ff @(posedge i_core_clk or posedge i_rst)
        if (i_rst) win <= 13'h0000;
        else win <= o_amb_measure ? win + 13'h0001 : 13'h0000;
    led_gate_a: assert property (o_led_enable != 2'h0 |-> o_acquire) else $error("led lit");
    bias_cut_a: assert property (o_acquire && o_in1_chan != 3'h0 |-> o_in1_bias == 3'h7)
        else $error("bias on");
    idle_park_a: assert property (!o_slot_busy |-> o_in1_bias == i_idle_state_first_pair && o_in1_chan == 3'h0)
        else $error("idle input");
    amb_span_a: assert property ($fell(o_amb_measure) |-> win == 13'h12C0) else $error("window");
    dark_wait_a: assert property (o_amb_measure |-> !o_acquire) else $error("early");
    diff_chan_a: assert property (i_inputs_three_four_differential |-> o_in3_chan <= 3'h2)
        else $error("diff chan");
    code_hold_a: assert property (o_acquire && $past(o_acquire) && !$past(i_dark_sample_done)
        |-> $stable(o_amb_code_ch1)) else $error("code moved");
    period_wake_a: assert property (o_period_start && !o_slot_busy |=> o_slot_busy) else $error("no wake");
endmodule
bind ots_sequencer ots_seq_chk chk_u (.*);

// ===== verification/ots_optic_model.sv
// Sensor side: ambient level and dark sample pulses.
// Level is flipped outside the window so a stale capture shows.
module ots_optic_model (
    input wire logic i_core_clk, o_acquire, o_amb_measure,
    output logic [8:0] i_amb_measured_ch1, i_amb_measured_ch2,
    output logic i_dark_sample_done
);
    logic [5:0] ph = 6'h00;
    assign i_amb_measured_ch1 = o_amb_measure ? 9'h0C5 : 9'h13A;
    assign i_amb_measured_ch2 = ~i_amb_measured_ch1;
    always @(posedge i_core_clk) ph <= o_acquire ? ph + 6'h01 : 6'h00;
    assign i_dark_sample_done = ph == 6'h3F;
endmodule

// ===== verification/testbench.sv
// Bench: timer source gaps, one coarse slot, then a fine and a host slot.
// Assumes the optic model drives the receiver feedback.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_core_clk = 0, i_rst = 1, i_ce = 1, i_timer_pin_clock_choice = 0, i_inputs_one_two_differential = 0;
    logic i_inputs_three_four_differential = 1, i_int_960k_tick = 0, i_ext_960k_tick = 0;
    logic i_ext_32m_tick = 0, i_ext_32k_tick = 0;
    logic [2:0] i_clock_source_select = 0, i_idle_state_first_pair = 3'h4, i_idle_state_second_pair = 3'h3;
    logic [15:0] i_slot_period = 16'h0002;
    logic [11:0] i_slot_enable = 0, i_slot_digital_integration = 0;
    logic [23:0] i_slot_led_enable = 0, i_slot_ambient_mode = 0;
    logic [83:0] i_slot_led_code_one = 0, i_slot_led_code_two = 0;
    logic [35:0] i_slot_route_first_pair = 0, i_slot_route_second_pair = 0, i_slot_precondition_select = 0;
    logic [95:0] i_slot_precon_width = 0, i_slot_pulse_width = 0;
    logic [107:0] i_host_ambient_code_channel_one = 0, i_host_ambient_code_channel_two = 0;
    wire [8:0] i_amb_measured_ch1, i_amb_measured_ch2, o_amb_code_ch1, o_amb_code_ch2;
    wire [6:0] o_led_code_one, o_led_code_two;
    wire [3:0] o_slot_index;
    wire [2:0] o_in1_chan, o_in2_chan, o_in3_chan, o_in4_chan, o_in1_bias, o_in2_bias, o_in3_bias, o_in4_bias;
    wire [1:0] o_led_enable;
    wire i_dark_sample_done, o_slot_busy, o_period_start, o_acquire, o_amb_measure, o_amb_subtract;
    wire o_first_pair_swap, o_second_pair_swap;
    wire [2:0] mon = {o_period_start, o_slot_busy, o_acquire};
    int err_total = 0, tests_run = 0, tcnt = 0;
    ots_sequencer dut_u (.*);
    ots_optic_model env_u (.*);
    initial forever #5 i_core_clk = ~i_core_clk;
    // Each tick source at its own rate
    always @(negedge i_core_clk) begin
        tcnt <= tcnt + 1;
        {i_int_960k_tick, i_ext_960k_tick} <= {tcnt % 10 == 0, tcnt % 12 == 0};
        {i_ext_32m_tick, i_ext_32k_tick} <= {tcnt % 2 == 0, tcnt % 30 == 0};
    end
    task chk(input string nm, input logic [31:0] e, g);
        tests_run++;
        if (e !== g) begin
            err_total++;
            $display("unexpected %s: expected %0h seen %0h", nm, e, g);
        end
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task wv(input int w, input logic v, output int n);
        n = 0;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (mon[w] !== v && n < 12000);
        if (n == 12000) begin
            err_total++;
            end_of_test;
        end
    endtask
    task clk_gaps;
        int n;
        int e[6] = '{20, 24, 20, 128, 24, 60};
        for (int k = 0; k < 6; k++) begin
            @(negedge i_core_clk);
            i_clock_source_select = 3'(k < 5 ? k : 4);
            i_timer_pin_clock_choice = k != 5;
            wv(2, 1, n);
            wv(2, 1, n);
            chk("tick gap", e[k], n);
        end
    endtask
    task coarse_slot;
        int n;
        @(negedge i_core_clk);
        i_clock_source_select = 3'h0;
        i_slot_period = 16'h0400;
        i_slot_enable = 12'h004;
        i_slot_route_first_pair = 36'h140;
        i_slot_route_second_pair = 36'h100;
        i_slot_led_enable = 24'h00_0030;
        i_slot_led_code_one = 84'h1F_C000;
        i_slot_led_code_two = 84'h4000;
        i_slot_precondition_select = 36'h40;
        i_slot_precon_width = 96'h1_0000;
        wv(2, 1, n);
        repeat (2) @(posedge i_core_clk);
        chk("precon bias", 3'h1, o_in1_bias);
        wv(0, 1, n);
        chk("precon and window", 4900, n);
        chk("slot index", 4'h2, o_slot_index);
        chk("leds", 16'hFF81, {o_led_enable, o_led_code_one, o_led_code_two});
        chk("routes", 9'h089, {o_in1_chan, o_in2_chan, o_in3_chan});
        wv(0, 0, n);
        chk("pulse span", 100, n);
        chk("ambient codes", 18'h1_8B3A, {o_amb_code_ch1, o_amb_code_ch2});
    endtask
    task fine_host;
        int n;
        @(negedge i_core_clk);
        i_slot_enable = 12'h00C;
        i_slot_ambient_mode = 24'h00_0090;
        i_slot_digital_integration = 12'h004;
        i_host_ambient_code_channel_one = 108'hA_A800_0000;
        wv(0, 1, n);
        wv(0, 0, n);
        chk("fine codes", 18'h2_74C5, {o_amb_code_ch1, o_amb_code_ch2});
        wv(0, 1, n);
        chk("host wait", 801, n);
        chk("host codes", 19'h5_5401, {o_amb_code_ch1, o_amb_code_ch2, o_amb_subtract});
    endtask
    initial begin
        repeat (8) @(posedge i_core_clk);
        @(negedge i_core_clk);
        i_rst = 0;
        clk_gaps();
        coarse_slot();
        fine_host();
        end_of_test;
    end
endmodule
